// File: dv/tb_usb_bdt_ownership_pullup.sv
`timescale 1ns/1ps
module tb_usb_bdt_ownership_pullup import ubo_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, vbus_pin = 1'b0, pu_en;
  logic tok_valid, tok_odd, xfer_done, g, n, s, r, tg;
  logic [3:0] tok_ep, tok_pid;
  logic [7:0] bc, bp;
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  ubo_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_pid(tok_pid), .tok_odd(tok_odd),
    .xfer_done(xfer_done), .sie_grant(g), .sie_nak(n), .sie_stall(s), .sie_release(r),
    .sie_data_toggle(tg), .sie_byte_count(bc), .sie_buf_ptr(bp), .vbus_pin(vbus_pin),
    .usb_dplus_pin_pullup_en(pu_en));
  ubo_sie_model sie (.pclk(pclk), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_pid(tok_pid),
    .tok_odd(tok_odd), .xfer_done(xfer_done), .sie_grant(g), .sie_nak(n), .sie_stall(s),
    .sie_release(r), .sie_data_toggle(tg), .sie_byte_count(bc), .sie_buf_ptr(bp));

  always #25 pclk = ~pclk;

  // Hang guard at 20000 cycles, well above the expected run of under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits for pready as long as it takes; only the hang guard ends a stuck access
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    bus(1'b1, a, d, x, e);
  endtask : wreg

  task automatic rreg(input logic [11:0] a, output logic [31:0] d);
    logic e;
    bus(1'b0, a, 32'h0, d, e);
  endtask : rreg

  initial begin
    logic [31:0] d;
    logic e, rel;
    logic [1:0] res;
    logic [16:0] f;
    logic [3:0] ep, pid;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rreg(CTRL_OFS, d);
    chk(d, 32'h0);
    bus(1'b0, 12'h010, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
    // ----------------------------------------------------------------
    // Pullup gating
    // ----------------------------------------------------------------
    wreg(CTRL_OFS, 32'h0000_7F07);
    repeat (6) @(posedge pclk);
    chk(32'(pu_en), 32'h0);
    vbus_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(pu_en), 32'h1);
    rreg(STAT_OFS, d);
    chk(32'(d[1:0]), 32'h3);
    wreg(CTRL_OFS, 32'h0000_7F05);
    repeat (4) @(posedge pclk);
    chk(32'(pu_en), 32'h0);
    vbus_pin <= 1'b0;
    wreg(CTRL_OFS, 32'h0000_7F0B);
    repeat (4) @(posedge pclk);
    chk(32'(pu_en), 32'h1);
    wreg(CTRL_OFS, 32'h0000_7F03);
    repeat (4) @(posedge pclk);
    chk(32'(pu_en), 32'h0);
    // ----------------------------------------------------------------
    // Descriptor table, ownership hand-over
    // ----------------------------------------------------------------
    wreg(RADDR_OFS, 32'h1E);
    wreg(RDATA_OFS, 32'h5A);
    wreg(RDATA_OFS, 32'hA5);
    for (int i = 0; i < 10; i++) begin
      wreg(RADDR_OFS, 32'(3 * i + 1));
      wreg(RDATA_OFS, 32'(i + 1));
      wreg(RDATA_OFS, 32'(8'h20 + 8 * i));
      wreg(RADDR_OFS, 32'(3 * i));
      wreg(RDATA_OFS, 32'h80 | (32'(i % 2) << 6));
    end
    for (int i = 0; i < 10; i++) begin
      ep = (i < 2) ? 4'h0 : (i < 6) ? 4'(i - 1) : 4'(5 + (i - 6) / 2);
      pid = (i == 0) ? PID_IN : (i == 1) ? PID_SETUP : (i[0] ? PID_IN : PID_OUT);
      sie.token(ep, pid, (i >= 6) ? i[0] : 1'b0, res, f);
      chk(32'(res), 32'h1);
      chk(32'(f), 32'({i[0], 8'(i + 1), 8'(8'h20 + 8 * i)}));
      sie.finish(i % 3, rel);
      chk(32'(rel), 32'h1);
      wreg(RADDR_OFS, 32'(3 * i));
      rreg(RDATA_OFS, d);
      chk(32'(d[7:0]), 32'({1'b0, i[0], pid, 2'b00}));
      sie.token(ep, pid, (i >= 6) ? i[0] : 1'b0, res, f);
      chk(32'(res), 32'h2);
      rreg(RDATA_OFS, d);
      chk(32'(d[7:0]), 32'(i + 1));
    end
    wreg(RADDR_OFS, 32'h06);
    wreg(RDATA_OFS, 32'h84);
    sie.token(4'h1, PID_OUT, 1'b0, res, f);
    chk(32'(res), 32'h3);
    wreg(CTRL_OFS, 32'h0000_3F03);
    sie.token(4'h6, PID_IN, 1'b0, res, f);
    chk(32'(res), 32'h0);
    wreg(RADDR_OFS, 32'h06);
    rreg(RDATA_OFS, d);
    chk(32'(d[7:0]), 32'h84);
    wreg(RADDR_OFS, 32'h1E);
    rreg(RDATA_OFS, d);
    chk(32'(d[7:0]), 32'h5A);
    rreg(RDATA_OFS, d);
    chk(32'(d[7:0]), 32'hA5);
    // ----------------------------------------------------------------
    // Buffer pointer into the reserved bytes
    // ----------------------------------------------------------------
    wreg(RADDR_OFS, 32'h06);
    wreg(RDATA_OFS, 32'h80);
    wreg(RADDR_OFS, 32'h08);
    wreg(RDATA_OFS, 32'h1F);
    sie.token(4'h1, PID_IN, 1'b0, res, f);
    chk(32'(res), 32'h2);
    rreg(STAT_OFS, d);
    chk(d, 32'h0000_0120);
    wreg(RADDR_OFS, 32'h06);
    rreg(RDATA_OFS, d);
    chk(32'(d[7:0]), 32'h80);
    report_and_stop;
  end
endmodule : tb_usb_bdt_ownership_pullup

// File: dv/ubo_sie_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial engine stand-in: issues tokens, ends data phases
// ----------------------------------------------------------------
module ubo_sie_model (
  // Clock
  input wire logic pclk,
  // Token side
  output logic tok_valid,
  output logic [3:0] tok_ep,
  output logic [3:0] tok_pid,
  output logic tok_odd,
  output logic xfer_done,
  // Answers
  input wire logic sie_grant,
  input wire logic sie_nak,
  input wire logic sie_stall,
  input wire logic sie_release,
  input wire logic sie_data_toggle,
  input wire logic [7:0] sie_byte_count,
  input wire logic [7:0] sie_buf_ptr
);
  initial begin
    tok_valid = 1'b0;
    tok_ep = 4'hF;
    tok_pid = 4'h0;
    tok_odd = 1'b0;
    xfer_done = 1'b0;
  end

  // Result 0 none, 1 grant, 2 nak, 3 stall; fields are toggle, count, pointer
  task automatic token(input logic [3:0] ep, input logic [3:0] pid, input logic odd,
                       output logic [1:0] res, output logic [16:0] fld);
    res = 2'h0;
    fld = 17'h0;
    @(posedge pclk);
    tok_valid <= 1'b1;
    tok_ep <= ep;
    tok_pid <= pid;
    tok_odd <= odd;
    @(posedge pclk);
    tok_valid <= 1'b0;
    // Fields are not held after the pulse, so a stale value cannot pass
    tok_ep <= ~ep;
    tok_pid <= ~pid;
    tok_odd <= ~odd;
    for (int i = 0; i < 8 && res == 2'h0; i++) begin
      @(posedge pclk);
      if (sie_grant) begin
        res = 2'h1;
        fld = {sie_data_toggle, sie_byte_count, sie_buf_ptr};
      end else if (sie_nak) begin
        res = 2'h2;
      end else if (sie_stall) begin
        res = 2'h3;
      end
    end
  endtask : token

  // Gap lets the data phase finish promptly or slowly
  task automatic finish(input int gap, output logic rel);
    rel = 1'b0;
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    xfer_done <= 1'b1;
    @(posedge pclk);
    xfer_done <= 1'b0;
    for (int i = 0; i < 6 && !rel; i++) begin
      @(posedge pclk);
      rel = sie_release;
    end
  endtask : finish
endmodule : ubo_sie_model

// File: include/ubo_pkg.sv
package ubo_pkg;

  // ----------------------------------------------------------------
  // USB RAM layout
  // ----------------------------------------------------------------
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] BD_BYTES = 8'h03;
  localparam logic [7:0] BD_OFS_CNT = 8'h01;
  localparam logic [7:0] BD_OFS_PTR = 8'h02;
  localparam logic [7:0] BDT_FIRST = 8'h00;
  localparam logic [7:0] BDT_LAST = 8'h1D;
  localparam logic [7:0] RSV_FIRST = 8'h1E;
  localparam logic [7:0] BUF_BASE = 8'h20;
  localparam logic [7:0] RAM_TOP = 8'hFF;

  // ----------------------------------------------------------------
  // Descriptor control byte fields
  // ----------------------------------------------------------------
  localparam int BD_OWN_BIT = 7;
  localparam int BD_DTOG_BIT = 6;
  localparam int BD_STALL_BIT = 2;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;

  // ----------------------------------------------------------------
  // Endpoint numbering
  // ----------------------------------------------------------------
  localparam logic [3:0] EP_COUNT = 4'h7;
  localparam logic [3:0] EP_DBL_FIRST = 4'h5;
  localparam logic [3:0] IDX_EP0_OUT = 4'h1;
  localparam logic [3:0] IDX_DBL_BASE = 4'h6;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] RADDR_OFS = 12'h008;
  localparam logic [11:0] RDATA_OFS = 12'h00C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PU_BIT = 1;
  localparam int CTRL_BUSPWR_BIT = 2;
  localparam int CTRL_SWVBUS_BIT = 3;
  localparam int CTRL_EP_LSB = 8;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam int STAT_VBUS_BIT = 0;
  localparam int STAT_PU_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_RES_LSB = 4;
  localparam int STAT_EP_LSB = 8;
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_GRANT = 2'h1;
  localparam logic [1:0] RES_NAK = 2'h2;
  localparam logic [1:0] RES_STALL = 2'h3;

  // Fixed endpoint/direction to descriptor address mapping
  function automatic logic [7:0] ubo_bd_addr(input logic [3:0] ep, input logic is_in, input logic odd);
    logic [3:0] idx;
    idx = 4'h0;
    if (ep == 4'h0) begin
      idx = is_in ? 4'h0 : IDX_EP0_OUT;
    end else if (ep < EP_DBL_FIRST) begin
      idx = ep + 4'h1;
    end else begin
      idx = IDX_DBL_BASE + {ep[2:0] - EP_DBL_FIRST[2:0], 1'b0} + {3'h0, odd};
    end
    return ({idx, 1'b0} + {4'h0, idx}) + BDT_FIRST;
  endfunction : ubo_bd_addr

endpackage : ubo_pkg

// File: include/ubo_ram_if.sv
`timescale 1ns/1ps
interface ubo_ram_if;
  logic en;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : ubo_ram_if

// File: rtl/ubo_pullup.sv
`timescale 1ns/1ps
module ubo_pullup
  import ubo_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sense and control
  input wire logic vbus_pin,
  input wire logic module_en,
  input wire logic dplus_pullup_select,
  input wire logic bus_powered,
  input wire logic sw_vbus_valid,
  // Results
  output logic vbus_sensed,
  output logic pullup_on
);

  logic vbus_meta;
  logic vbus_sync;
  logic vbus_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_meta <= 1'b0;
      vbus_sync <= 1'b0;
    end else begin
      vbus_meta <= vbus_pin;
      vbus_sync <= vbus_meta;
    end
  end

  // Self-powered systems sense VBUS themselves and report it by software
  assign vbus_ok = bus_powered ? vbus_sync : sw_vbus_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_sensed <= 1'b0;
      pullup_on <= 1'b0;
    end else begin
      vbus_sensed <= vbus_ok;
      pullup_on <= module_en && dplus_pullup_select && vbus_ok;
    end
  end

  pullup_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn) !vbus_ok |=> !pullup_on)
    else $error("pullup applied without valid vbus");

  bus_sense_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (bus_powered && module_en && dplus_pullup_select && vbus_sync)[*2] |-> pullup_on)
    else $error("pullup not enabled on sensed vbus");

endmodule : ubo_pullup

// File: rtl/ubo_ram.sv
`timescale 1ns/1ps
module ubo_ram
  import ubo_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Access port
  ubo_ram_if.mem m
);

  logic [7:0] mem [RAM_DEPTH];

  always_ff @(posedge pclk) begin
    if (m.en && m.we) begin
      mem[m.addr] <= m.wdata;
    end
  end

  // Read data held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m.rdata <= 8'h00;
    end else if (m.en && !m.we) begin
      m.rdata <= mem[m.addr];
    end
  end

endmodule : ubo_ram

// File: rtl/ubo_top.sv
`timescale 1ns/1ps
// What this block does
// - Apply the D+ pullup only while valid VBUS is sensed, otherwise removed.
// - Bus-powered mode senses VBUS in hardware to gate the pullup.
// - Pullup-select control bit switches the internal D+ pullup on.
// - Each descriptor occupies three consecutive bytes of USB RAM.
// - Ownership zero: CPU owns descriptor and buffer, free access.
// - Ownership one: module owns descriptor and buffer; CPU must not modify.
// - Endpoint zero has separate IN and OUT descriptors.
// - Double-buffered endpoints use even and odd descriptors.
// - Descriptor table fills the first thirty bytes of USB RAM.
// - Order: EP0 IN, EP0 OUT, EP1..4, EP5 even/odd, EP6 even/odd.
// - Two reserved bytes follow; buffers live from 0x20 to the top.
// - Endpoint-to-descriptor mapping is fixed in hardware.
// - A token to an enabled endpoint consults the table first.
// - Fetch matching descriptor and check ownership before using it.
// - After completing a token, write ownership zero back.
// - Ignore all other descriptor fields when ownership is zero.
module ubo_top
  import ubo_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Token side of the serial engine
  input wire logic tok_valid,
  input wire logic [3:0] tok_ep,
  input wire logic [3:0] tok_pid,
  input wire logic tok_odd,
  input wire logic xfer_done,
  // Answers to the serial engine
  output logic sie_grant,
  output logic sie_nak,
  output logic sie_stall,
  output logic sie_release,
  output logic sie_data_toggle,
  output logic [7:0] sie_byte_count,
  output logic [7:0] sie_buf_ptr,
  // Pins
  input wire logic vbus_pin,
  output logic usb_dplus_pin_pullup_en
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_RD0   = 6'b000010,
    S_RD1   = 6'b000100,
    S_RD2   = 6'b001000,
    S_WAITD = 6'b010000,
    S_WB    = 6'b100000
  } ubo_state_e;

  ubo_state_e st;
  ubo_ram_if ram ();

  logic ctrl_en;
  logic ctrl_pu;
  logic ctrl_buspwr;
  logic ctrl_swvbus;
  logic [6:0] ep_en;
  logic [7:0] raddr;
  logic ram_wait;
  logic vbus_sensed;
  logic [7:0] bd_base;
  logic [7:0] bd_ctrl;
  logic [3:0] tok_pid_q;
  logic [3:0] tok_ep_q;
  logic [1:0] last_res;
  logic apb_acc;
  logic is_rdata;
  logic hit;
  logic [31:0] reg_rd;
  logic cpu_ram_rd;
  logic cpu_ram_wr;
  logic fsm_ram;
  logic fsm_we;
  logic [7:0] fsm_addr;
  logic [7:0] fsm_wdata;
  logic take;
  logic own;
  logic stall;
  logic ptr_ok;

  // ----------------------------------------------------------------
  // Buffer RAM and pullup control
  // ----------------------------------------------------------------
  ubo_ram u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .m(ram.mem)
  );

  ubo_pullup u_pullup (
    .pclk(pclk),
    .presetn(presetn),
    .vbus_pin(vbus_pin),
    .module_en(ctrl_en),
    .dplus_pullup_select(ctrl_pu),
    .bus_powered(ctrl_buspwr),
    .sw_vbus_valid(ctrl_swvbus),
    .vbus_sensed(vbus_sensed),
    .pullup_on(usb_dplus_pin_pullup_en)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_acc = psel && penable && !pready;
  assign is_rdata = (paddr == RDATA_OFS);
  assign hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == RADDR_OFS) || is_rdata;

  // The descriptor engine wins the RAM; the CPU waits for as many cycles as the engine holds the port
  assign cpu_ram_rd = apb_acc && is_rdata && !pwrite && !ram_wait && !fsm_ram;
  assign cpu_ram_wr = apb_acc && is_rdata && pwrite && !fsm_ram;

  always_comb begin
    reg_rd = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: begin
        reg_rd[CTRL_EN_BIT] = ctrl_en;
        reg_rd[CTRL_PU_BIT] = ctrl_pu;
        reg_rd[CTRL_BUSPWR_BIT] = ctrl_buspwr;
        reg_rd[CTRL_SWVBUS_BIT] = ctrl_swvbus;
        reg_rd[CTRL_EP_LSB +: 7] = ep_en;
      end
      STAT_OFS: begin
        reg_rd[STAT_VBUS_BIT] = vbus_sensed;
        reg_rd[STAT_PU_BIT] = usb_dplus_pin_pullup_en;
        reg_rd[STAT_BUSY_BIT] = (st != S_IDLE);
        reg_rd[STAT_RES_LSB +: 2] = last_res;
        reg_rd[STAT_EP_LSB +: 4] = tok_ep_q;
      end
      RADDR_OFS: begin
        reg_rd[7:0] = raddr;
      end
      default: begin
        reg_rd = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (apb_acc) begin
        if (is_rdata && pwrite) begin
          pready <= !fsm_ram;
        end else if (is_rdata) begin
          if (ram_wait) begin
            pready <= 1'b1;
            prdata <= {24'h00_0000, ram.rdata};
          end
        end else begin
          pready <= 1'b1;
          pslverr <= !hit;
          prdata <= reg_rd;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_wait <= 1'b0;
    end else if (cpu_ram_rd) begin
      ram_wait <= 1'b1;
    end else if (apb_acc && ram_wait) begin
      ram_wait <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ep_en, ctrl_swvbus, ctrl_buspwr, ctrl_pu, ctrl_en} <= CTRL_RESET;
    end else if (apb_acc && pwrite && paddr == CTRL_OFS) begin
      ctrl_en <= pwdata[CTRL_EN_BIT];
      ctrl_pu <= pwdata[CTRL_PU_BIT];
      ctrl_buspwr <= pwdata[CTRL_BUSPWR_BIT];
      ctrl_swvbus <= pwdata[CTRL_SWVBUS_BIT];
      ep_en <= pwdata[CTRL_EP_LSB +: 7];
    end
  end

  // RAM window address steps after each data access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raddr <= 8'h00;
    end else if (apb_acc && pwrite && paddr == RADDR_OFS) begin
      raddr <= pwdata[7:0];
    end else if (cpu_ram_wr || (apb_acc && ram_wait)) begin
      raddr <= raddr + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // RAM port sharing
  // ----------------------------------------------------------------
  always_comb begin
    ram.en = fsm_ram || cpu_ram_rd || cpu_ram_wr;
    ram.we = fsm_ram ? fsm_we : cpu_ram_wr;
    ram.addr = fsm_ram ? fsm_addr : raddr;
    ram.wdata = fsm_ram ? fsm_wdata : pwdata[7:0];
  end

  // ----------------------------------------------------------------
  // Descriptor engine
  // ----------------------------------------------------------------
  assign take = tok_valid && ctrl_en && (tok_ep < EP_COUNT) && ep_en[tok_ep[2:0]];
  assign own = ram.rdata[BD_OWN_BIT];
  assign stall = ram.rdata[BD_STALL_BIT];
  // Pointers into the table or reserved bytes would corrupt descriptors
  assign ptr_ok = (ram.rdata >= BUF_BASE) && (ram.rdata <= RAM_TOP);

  always_comb begin
    fsm_ram = 1'b0;
    fsm_we = 1'b0;
    fsm_addr = bd_base;
    fsm_wdata = 8'h00;
    case (st)
      S_IDLE: begin
        if (take) begin
          fsm_ram = 1'b1;
          fsm_addr = ubo_bd_addr(tok_ep, tok_pid == PID_IN, tok_odd);
        end
      end
      S_RD0: begin
        if (own && !stall) begin
          fsm_ram = 1'b1;
          fsm_addr = bd_base + BD_OFS_CNT;
        end
      end
      S_RD1: begin
        fsm_ram = 1'b1;
        fsm_addr = bd_base + BD_OFS_PTR;
      end
      S_WB: begin
        fsm_ram = 1'b1;
        fsm_we = 1'b1;
        fsm_wdata = {1'b0, bd_ctrl[BD_DTOG_BIT], tok_pid_q, 2'b00};
      end
      default: begin
        fsm_ram = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
    end else begin
      case (st)
        S_IDLE: begin
          if (take) begin
            st <= S_RD0;
          end
        end
        S_RD0: begin
          if (!own || stall) begin
            st <= S_IDLE;
          end else begin
            st <= S_RD1;
          end
        end
        S_RD1: begin
          st <= S_RD2;
        end
        S_RD2: begin
          st <= ptr_ok ? S_WAITD : S_IDLE;
        end
        S_WAITD: begin
          if (xfer_done) begin
            st <= S_WB;
          end
        end
        S_WB: begin
          st <= S_IDLE;
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // Token context and descriptor fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bd_base <= 8'h00;
      tok_pid_q <= 4'h0;
      tok_ep_q <= 4'h0;
      bd_ctrl <= 8'h00;
    end else if (st == S_IDLE && take) begin
      bd_base <= fsm_addr;
      tok_pid_q <= tok_pid;
      tok_ep_q <= tok_ep;
    end else if (st == S_RD0 && own) begin
      bd_ctrl <= ram.rdata;
    end
  end

  // ----------------------------------------------------------------
  // Answers to the serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sie_grant <= 1'b0;
      sie_nak <= 1'b0;
      sie_stall <= 1'b0;
      sie_release <= 1'b0;
      sie_data_toggle <= 1'b0;
      sie_byte_count <= 8'h00;
      sie_buf_ptr <= 8'h00;
      last_res <= RES_NONE;
    end else begin
      sie_grant <= 1'b0;
      sie_nak <= 1'b0;
      sie_stall <= 1'b0;
      sie_release <= (st == S_WB);
      case (st)
        S_RD0: begin
          if (!own) begin
            sie_nak <= 1'b1;
            last_res <= RES_NAK;
          end else if (stall) begin
            sie_stall <= 1'b1;
            last_res <= RES_STALL;
          end
        end
        S_RD1: begin
          sie_byte_count <= ram.rdata;
          sie_data_toggle <= bd_ctrl[BD_DTOG_BIT];
        end
        S_RD2: begin
          sie_buf_ptr <= ram.rdata;
          sie_grant <= ptr_ok;
          sie_nak <= !ptr_ok;
          last_res <= ptr_ok ? RES_GRANT : RES_NAK;
        end
        default: begin
          last_res <= last_res;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  own_nak_a:
    assert property ((st == S_RD0 && !own) |=> (sie_nak && st == S_IDLE && !fsm_we))
    else $error("cpu-owned descriptor not answered with nak");

  ignore_fields_a:
    assert property ((st == S_RD0 && !own) |=> (!sie_grant && !sie_stall) [*2])
    else $error("fields of cpu-owned descriptor acted on");

  release_own_a:
    assert property ((st == S_WAITD && xfer_done) |=>
      (fsm_we && !fsm_wdata[BD_OWN_BIT] && ram.addr == bd_base))
    else $error("ownership not handed back");

  table_bound_a:
    assert property ((st == S_IDLE && take) |-> (fsm_addr <= BDT_LAST - BD_OFS_PTR))
    else $error("descriptor outside table");

  bd_map_a:
    assert property ((st == S_IDLE && take && tok_ep == 4'h0) |->
      (fsm_addr == ((tok_pid == PID_IN) ? BDT_FIRST : BD_BYTES)))
    else $error("endpoint zero descriptor misplaced");

  grant_owned_a:
    assert property (sie_grant |-> (bd_ctrl[BD_OWN_BIT] && $past(st, 2) == S_RD1))
    else $error("grant without module ownership");

  disabled_tok_a:
    assert property ((st == S_IDLE && tok_valid && !take) |=> (st == S_IDLE && !sie_nak))
    else $error("disabled endpoint token processed");

  fetch_order_a:
    assert property ((st == S_RD0 && own && !stall) |-> ##1 (ram.addr == bd_base + BD_OFS_PTR)
      ##1 (st == S_RD2))
    else $error("descriptor fetch out of order");

  cpu_write_a:
    assert property ((apb_acc && is_rdata && pwrite && st == S_IDLE && !take) |=> pready)
    else $error("cpu ram write blocked while engine idle");

  grant_c: cover property (sie_grant ##[1:20] sie_release);
  nak_c: cover property (sie_nak);
  stall_c: cover property (sie_stall);
  pullup_c: cover property ($rose(usb_dplus_pin_pullup_en));

endmodule : ubo_top
